// ### hdl/arb_timer_pkg.sv
package arb_timer_pkg;

  // Register byte offsets on the bus.
  localparam logic [4:0] OFF_CONTROL   = 5'h00;
  localparam logic [4:0] OFF_COUNT_LOW = 5'h04;
  localparam logic [4:0] OFF_IRQ_STAT  = 5'h08;
  localparam logic [4:0] OFF_IRQ_MASK  = 5'h0c;

  // Control register field positions.
  localparam int CTL_MODE_UPPER = 7;
  localparam int CTL_MODE_LOWER = 6;
  localparam int CTL_LOST       = 5;
  localparam int CTL_CLK_SEL    = 4;
  localparam int CTL_DONE       = 3;
  localparam int CTL_RUNNING    = 2;
  localparam int CTL_OVERFLOW   = 1;
  localparam int CTL_MSB        = 0;

  // Interrupt status and mask bit positions.
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_OVERFLOW = 1;
  localparam int IRQ_LOST     = 2;
  localparam int IRQ_WIDTH    = 3;

  // Mode field codes.
  localparam logic [1:0] MODE_IDLE     = 2'h0;
  localparam logic [1:0] MODE_MEASURE  = 2'h1;
  localparam logic [1:0] MODE_ARBITER  = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;

  // Counter geometry and arbitration sample points.
  localparam int         CNT_WIDTH      = 9;
  localparam logic [8:0] CNT_RESET      = 9'h000;
  localparam logic [8:0] SAMPLE_AT_BUS  = 9'h038;
  localparam logic [8:0] SAMPLE_AT_PRES = 9'h008;

  // Bus clock divider for the quarter-rate count tick.
  localparam logic [1:0] QDIV_LAST = 2'h3;

  // Reset values.
  localparam logic [1:0]  MODE_RESET = MODE_IDLE;
  localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 3'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Bus request as seen by the slave.
  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } bus_req_s;

  // Control and status carried between the register file and the counter.
  typedef struct packed {
    logic [1:0] mode;
    logic       clk_sel;
    logic       lost;
    logic       done;
    logic       running;
    logic       overflow;
  } ctl_s;

endpackage

// ### hdl/serial_line_arbiter_timer.sv
// Behaviour
// (RL1) Nine-bit up-counter with separate overflow bit.
// (RL2) Two-bit mode: idle, measure, arbitrate, reserved.
// (RL3) Reset clears mode, clock select, flags, counter.
// (RL4) Lost flag clears when upper mode bit written 0.
// (RL5) Clock select: half prescaler or quarter bus.
// (RL6) Done flag set at end; control write clears.
// (RL7) Running flag reads one while counter counts.
// (RL8) Overflow flag set on overflow; control write clears.
// (RL9) MSB in control, low byte in data; write clears.
// (RL10) Idle mode holds counter cleared and stopped.
// (RL11) Quarter clock: falling edge starts, next stops.
// (RL12) Prescaler clock: low starts, rising edge stops.
// (RL13) Arbitration restarts counter on transmit rising edge.
// (RL14) Sample receive at 0x38 or 0x08; low loses.
// (RL15) Lost flag forces transmit pin high.
// (RL16) Transmit low before loss resets, awaits rising edge.
// (RL17) Counter wraps to zero and sets overflow.
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module serial_line_arbiter_timer (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        rxd_i,
  input  wire logic        tx_core_i,
  input  wire logic        presc_tick_i,
  output logic             txd_o,
  output logic             irq_o
);

  // Whole module state in one record.
  typedef struct packed {
    logic                 rx_s1;
    logic                 rx_s2;
    logic                 rx_prev;
    logic                 tx_prev;
    logic [1:0]           qdiv;
    logic                 phalf;
    logic [8:0]           count;
    logic                 sampled;
    arb_timer_pkg::ctl_s  ctl;
    logic [2:0]           irq_stat;
    logic [2:0]           irq_mask;
    logic                 wait_req;
    logic [31:0]          rdata;
    logic                 txd;
    logic                 irq;
  } state_s;

  state_s                 s_q;
  state_s                 s_d;
  arb_timer_pkg::bus_req_s req;

  assign req.address   = avs_address_i;
  assign req.read      = avs_read_i;
  assign req.write     = avs_write_i;
  assign req.writedata = avs_writedata_i;

  // Outputs come straight from the state flip-flops.
  assign avs_readdata_o    = s_q.rdata;
  assign avs_waitrequest_o = s_q.wait_req;
  assign txd_o             = s_q.txd;
  assign irq_o             = s_q.irq;

  // Next-state logic for bus slave, counter and flags.
  always_comb
  begin
    logic       accept;
    logic       ctl_wr;
    logic       tick;
    logic       rx_fall;
    logic       rx_rise;
    logic       tx_rise;
    logic       ev_done;
    logic       ev_ovf;
    logic       ev_lost;
    logic [8:0] sample_pt;
    logic [9:0] inc;
    logic [2:0] ev;
    logic [7:0] ctl_rd;
    s_d       = s_q;
    accept    = 1'b0;
    ctl_wr    = 1'b0;
    tick      = 1'b0;
    rx_fall   = 1'b0;
    rx_rise   = 1'b0;
    tx_rise   = 1'b0;
    ev_done   = 1'b0;
    ev_ovf    = 1'b0;
    ev_lost   = 1'b0;
    sample_pt = arb_timer_pkg::SAMPLE_AT_BUS;
    inc       = 10'h000;
    ev        = 3'h0;
    ctl_rd    = 8'h00;

    // The receive pin crosses in through two flops; only the second is used.
    s_d.rx_s1   = rxd_i;
    s_d.rx_s2   = s_q.rx_s1;
    s_d.rx_prev = s_q.rx_s2;
    s_d.tx_prev = tx_core_i;
    rx_fall     = s_q.rx_prev & ~s_q.rx_s2;
    rx_rise     = ~s_q.rx_prev & s_q.rx_s2;
    tx_rise     = tx_core_i & ~s_q.tx_prev;

    // Count tick: a quarter of the bus clock or half the prescaler tick rate.
    s_d.qdiv = s_q.qdiv + 2'h1;
    if (presc_tick_i)
    begin
      s_d.phalf = ~s_q.phalf;
    end
    if (s_q.ctl.clk_sel)
    begin
      tick      = presc_tick_i & s_q.phalf; // RL5
      sample_pt = arb_timer_pkg::SAMPLE_AT_PRES;
    end
    else
    begin
      tick = (s_q.qdiv == arb_timer_pkg::QDIV_LAST); // RL5
    end

    // Bus slave: one wait cycle, then the request is accepted.
    accept       = (req.read | req.write) & ~s_q.wait_req;
    s_d.wait_req = ~((req.read | req.write) & s_q.wait_req);
    ctl_wr       = accept & req.write & (req.address == arb_timer_pkg::OFF_CONTROL);

    // Counter advance with wrap; the tenth bit is the carry out.
    inc = {1'b0, s_q.count} + 10'h001;
    if (s_q.ctl.running && tick)
    begin
      s_d.count = inc[8:0]; // RL1
      if (inc[9])
      begin
        ev_ovf = 1'b1; // RL17
      end
    end

    // Mode behaviour.
    unique case (s_q.ctl.mode)
      arb_timer_pkg::MODE_MEASURE:
      begin
        if (!s_q.ctl.clk_sel)
        begin
          // Restart is blocked until software clears the done flag.
          if (rx_fall && !s_q.ctl.running && !s_q.ctl.done)
          begin
            s_d.count       = arb_timer_pkg::CNT_RESET;
            s_d.ctl.running = 1'b1; // RL11
          end
          else if (rx_fall && s_q.ctl.running)
          begin
            s_d.ctl.running = 1'b0; // RL11
            ev_done         = 1'b1; // RL11
          end
        end
        else
        begin
          if (!s_q.rx_s2 && !s_q.ctl.running && !s_q.ctl.done)
          begin
            s_d.count       = arb_timer_pkg::CNT_RESET;
            s_d.ctl.running = 1'b1; // RL12
          end
          else if (rx_rise && s_q.ctl.running)
          begin
            s_d.ctl.running = 1'b0; // RL12
            ev_done         = 1'b1; // RL12
          end
        end
      end
      arb_timer_pkg::MODE_ARBITER:
      begin
        if (tx_rise)
        begin
          s_d.count       = arb_timer_pkg::CNT_RESET; // RL13
          s_d.ctl.running = 1'b1; // RL13
          s_d.sampled     = 1'b0;
        end
        else if (!tx_core_i && s_q.ctl.running && !s_q.ctl.lost)
        begin
          // Own dominant bit before any loss: wait for the next rising edge.
          s_d.count       = arb_timer_pkg::CNT_RESET; // RL16
          s_d.ctl.running = 1'b0; // RL16
        end
        else if (s_q.ctl.running && !s_q.sampled && s_q.count == sample_pt)
        begin
          s_d.sampled = 1'b1; // RL14
          if (!s_q.rx_s2)
          begin
            ev_lost = 1'b1; // RL14
          end
        end
      end
      default:
      begin
        // Idle and the reserved code keep the counter cleared and stopped.
        s_d.count       = arb_timer_pkg::CNT_RESET; // RL10
        s_d.ctl.running = 1'b0; // RL10 RL2
        s_d.sampled     = 1'b0;
      end
    endcase

    // Control write: new mode and clock select; done, overflow, running and counter cleared; lost cleared only when upper mode bit is 0.
    if (ctl_wr)
    begin
      s_d.ctl.mode     = {req.writedata[arb_timer_pkg::CTL_MODE_UPPER],
                          req.writedata[arb_timer_pkg::CTL_MODE_LOWER]}; // RL2
      s_d.ctl.clk_sel  = req.writedata[arb_timer_pkg::CTL_CLK_SEL]; // RL5
      s_d.count        = arb_timer_pkg::CNT_RESET; // RL9
      s_d.ctl.running  = 1'b0;
      s_d.sampled      = 1'b0;
      s_d.ctl.done     = 1'b0; // RL6
      s_d.ctl.overflow = 1'b0; // RL8
      if (!req.writedata[arb_timer_pkg::CTL_MODE_UPPER])
      begin
        s_d.ctl.lost = 1'b0; // RL4
      end
    end

    // Events are applied last so a set wins over a same-cycle clear.
    if (ev_done)
    begin
      s_d.ctl.done = 1'b1; // RL6
    end
    if (ev_ovf)
    begin
      s_d.ctl.overflow = 1'b1; // RL8 RL17
    end
    if (ev_lost)
    begin
      s_d.ctl.lost = 1'b1; // RL14
    end
    s_d.ctl.running = s_d.ctl.running; // RL7

    // Interrupt status: sticky, write one to clear, events win.
    ev[arb_timer_pkg::IRQ_DONE]     = ev_done;
    ev[arb_timer_pkg::IRQ_OVERFLOW] = ev_ovf;
    ev[arb_timer_pkg::IRQ_LOST]     = ev_lost;
    if (accept && req.write && req.address == arb_timer_pkg::OFF_IRQ_STAT)
    begin
      s_d.irq_stat = s_q.irq_stat & ~req.writedata[2:0];
    end
    if (accept && req.write && req.address == arb_timer_pkg::OFF_IRQ_MASK)
    begin
      s_d.irq_mask = req.writedata[2:0];
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq      = |(s_q.irq_stat & s_q.irq_mask);

    // Transmit pin is held recessive while arbitration is lost.
    s_d.txd = tx_core_i | s_q.ctl.lost; // RL15

    // Read data is captured in the wait cycle; unmapped reads give zero.
    ctl_rd[arb_timer_pkg::CTL_MODE_UPPER] = s_q.ctl.mode[1];
    ctl_rd[arb_timer_pkg::CTL_MODE_LOWER] = s_q.ctl.mode[0];
    ctl_rd[arb_timer_pkg::CTL_LOST]       = s_q.ctl.lost;
    ctl_rd[arb_timer_pkg::CTL_CLK_SEL]    = s_q.ctl.clk_sel;
    ctl_rd[arb_timer_pkg::CTL_DONE]       = s_q.ctl.done;
    ctl_rd[arb_timer_pkg::CTL_RUNNING]    = s_q.ctl.running; // RL7
    ctl_rd[arb_timer_pkg::CTL_OVERFLOW]   = s_q.ctl.overflow;
    ctl_rd[arb_timer_pkg::CTL_MSB]        = s_q.count[8]; // RL9
    if (req.read && s_q.wait_req)
    begin
      unique case (req.address)
        arb_timer_pkg::OFF_CONTROL:   s_d.rdata = {24'h000000, ctl_rd};
        arb_timer_pkg::OFF_COUNT_LOW: s_d.rdata = {24'h000000, s_q.count[7:0]}; // RL9
        arb_timer_pkg::OFF_IRQ_STAT:  s_d.rdata = {29'h00000000, s_q.irq_stat};
        arb_timer_pkg::OFF_IRQ_MASK:  s_d.rdata = {29'h00000000, s_q.irq_mask};
        default:                      s_d.rdata = arb_timer_pkg::RDATA_RESET;
      endcase
    end
  end

  // State register; reset clears mode, select, flags and counter.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_q.rx_s1        <= 1'b1;
      s_q.rx_s2        <= 1'b1;
      s_q.rx_prev      <= 1'b1;
      s_q.tx_prev      <= 1'b1;
      s_q.qdiv         <= 2'h0;
      s_q.phalf        <= 1'b0;
      s_q.count        <= arb_timer_pkg::CNT_RESET; // RL3
      s_q.sampled      <= 1'b0;
      s_q.ctl.mode     <= arb_timer_pkg::MODE_RESET; // RL3
      s_q.ctl.clk_sel  <= 1'b0; // RL3
      s_q.ctl.lost     <= 1'b0; // RL3
      s_q.ctl.done     <= 1'b0; // RL3
      s_q.ctl.running  <= 1'b0; // RL3
      s_q.ctl.overflow <= 1'b0; // RL3
      s_q.irq_stat     <= arb_timer_pkg::IRQ_RESET;
      s_q.irq_mask     <= arb_timer_pkg::IRQ_RESET;
      s_q.wait_req     <= 1'b1;
      s_q.rdata        <= arb_timer_pkg::RDATA_RESET;
      s_q.txd          <= 1'b1;
      s_q.irq          <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule // serial_line_arbiter_timer

// ### test/bus_node_model.sv
`timescale 1ns/1ps
// Other node on the shared open-drain line; a pull-up keeps it high when nobody drives.
module bus_node_model (
  input  wire logic txd_i,
  input  wire logic dom_i,
  output logic      rxd_o
);
  // Wired-AND: either node pulling low wins, which is what makes arbitration lossy.
  assign rxd_o = txd_i & ~dom_i;
endmodule // bus_node_model

// ### test/serial_line_arbiter_timer_checker.sv
`timescale 1ns/1ps
module arb_timer_checker (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        tx_core_i,
  input wire logic        txd_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic wr_ok;
  // A write is taken only at the edge where waitrequest is low.
  assign wr_ok = avs_write_i && !avs_waitrequest_o;
  a_wait_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered next cycle");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without a read");
  a_ctl_upper: assert property (avs_read_i && avs_waitrequest_o && avs_address_i == 5'h00
    |=> avs_readdata_o[31:8] == 24'h0) else $error("control upper bits not zero");
  a_unmapped_zero: assert property (avs_read_i && avs_waitrequest_o && avs_address_i >= 5'h10
    |=> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  a_tx_pass: assert property (tx_core_i |=> txd_o)
    else $error("transmit pin low while core sends high");
  a_lost_clear: assert property (wr_ok && avs_address_i == 5'h00 && !avs_writedata_i[7]
    ##1 !tx_core_i |=> !txd_o) else $error("transmit still forced after clear");
  a_irq_mask: assert property (wr_ok && avs_address_i == 5'h0c && avs_writedata_i[2:0] == 3'h0
    |=> ##1 !irq_o) else $error("interrupt high with all masked");
endmodule // arb_timer_checker
bind serial_line_arbiter_timer arb_timer_checker chk_i (.clk_i(clk_i), .rstn_i(rstn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .tx_core_i(tx_core_i), .txd_o(txd_o), .irq_o(irq_o));

// ### test/serial_line_arbiter_timer_tb.sv
`timescale 1ns/1ps
module serial_line_arbiter_timer_tb;
  // The core's transmit output idles high so that the shared line rests recessive.
  logic clk_i = 1'b0, rstn_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0, tx = 1'b1, dom = 1'b0;
  logic pt = 1'b0, rxd, txd, irq, wait_o;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0, rdo, rdat;
  int n_errors = 0, checks = 0, cyc = 0;
  // Clock at 100 MHz and a prescaler pulse every other cycle.
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) pt <= ~pt;
  serial_line_arbiter_timer uut (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(adr),
    .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wd), .avs_readdata_o(rdo),
    .avs_waitrequest_o(wait_o), .rxd_i(rxd), .tx_core_i(tx), .presc_tick_i(pt),
    .txd_o(txd), .irq_o(irq));
  bus_node_model node (.txd_i(txd), .dom_i(dom), .rxd_o(rxd));
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One Avalon transfer; the request stands until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    rd_i <= !w;
    wr_i <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (wait_o !== 1'b0);
    rdat = rdo;
    rd_i <= 1'b0;
    wr_i <= 1'b0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Hang guard well above the few thousand cycles the sequence needs.
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  initial
  begin
    wt(16);
    rstn_i <= 1'b1;
    rc(5'h00, 32'h0);
    rc(5'h04, 32'h0);
    rc(5'h10, 32'h0);
    chk(txd, 1'b1);
    // Measure between two falls on the quarter bus clock.
    bus(1'b1, 5'h00, 32'h40);
    wt(4);
    dom <= 1'b1;
    wt(40);
    dom <= 1'b0;
    wt(40);
    dom <= 1'b1;
    wt(10);
    dom <= 1'b0;
    wt(10);
    rc(5'h00, 32'h48);
    bus(1'b0, 5'h04, 32'h0);
    chk(32'(rdat inside {[32'h13:32'h15]}), 32'h1);
    rc(5'h08, 32'h1);
    bus(1'b1, 5'h0c, 32'h7);
    wt(2);
    chk(irq, 1'b1);
    bus(1'b1, 5'h0c, 32'h0);
    wt(2);
    chk(irq, 1'b0);
    bus(1'b1, 5'h00, 32'h40);
    rc(5'h00, 32'h40);
    // Break timing on the prescaler clock, line already low at enable.
    dom <= 1'b1;
    bus(1'b1, 5'h00, 32'h50);
    wt(20);
    rc(5'h00, 32'h54);
    dom <= 1'b0;
    wt(10);
    rc(5'h00, 32'h58);
    // Hold the line low long enough for the counter to wrap.
    bus(1'b1, 5'h00, 32'h40);
    dom <= 1'b1;
    wt(2100);
    rc(5'h00, 32'h46);
    dom <= 1'b0;
    bus(1'b1, 5'h00, 32'h40);
    rc(5'h00, 32'h40);
    rc(5'h04, 32'h0);
    rc(5'h08, 32'h3);
    bus(1'b1, 5'h08, 32'h3);
    rc(5'h08, 32'h0);
    // Arbitration lost against a dominant node; the core drops then raises its output.
    bus(1'b1, 5'h00, 32'h80);
    tx <= 1'b0;
    wt(2);
    tx <= 1'b1;
    dom <= 1'b1;
    wt(260);
    bus(1'b0, 5'h00, 32'h0);
    chk(rdat & 32'h20, 32'h20);
    tx <= 1'b0;
    wt(3);
    chk(txd, 1'b1);
    dom <= 1'b0;
    rc(5'h08, 32'h4);
    bus(1'b1, 5'h00, 32'h0);
    rc(5'h00, 32'h0);
    wt(2);
    chk(txd, 1'b0);
    // Transmit drops before any sample: counter clears and waits.
    bus(1'b1, 5'h00, 32'h80);
    tx <= 1'b1;
    wt(40);
    tx <= 1'b0;
    wt(5);
    rc(5'h00, 32'h80);
    rc(5'h04, 32'h0);
    tx <= 1'b1;
    wt(3);
    rc(5'h00, 32'h84);
    wrap_up();
  end
endmodule // serial_line_arbiter_timer_tb
